// file: adc_avg_mux.sv
// Averaging sequencer and step input selection with a Wishbone register slave.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
module adc_avg_mux
  import adc_avg_pkg::*;
#(
  parameter int DATA_W = 10
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic seqStart,
  output logic seqBusy,
  output logic convReq,
  output logic [2:0] convChannel,
  output logic convTempSel,
  output logic convDiff,
  input wire logic convDone,
  input wire logic [DATA_W-1:0] convData,
  output logic fifoWrite,
  output logic [DATA_W-1:0] fifoData
);

  localparam int ACC_W = DATA_W + EXP_MAX_BITS;

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  logic [31:0] avgCtl;
  logic [31:0] inSel;
  logic [31:0] stepCtl;
  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWrite = busReq & wb_we_i;
  wire [ADDR_W-3:0] wordAdr = wb_adr_i[ADDR_W-1:2];
  wire hitAvg = wordAdr == OFF_AVG_CTL[ADDR_W-1:2];
  wire hitSel = wordAdr == OFF_IN_SEL[ADDR_W-1:2];
  wire hitCtl = wordAdr == OFF_STEP_CTL[ADDR_W-1:2];

  // Unmapped addresses read as zero; reserved bits are already held at zero.
  wire [31:0] readMux = hitAvg ? avgCtl : hitSel ? inSel : hitCtl ? stepCtl : 32'h0000_0000;

  // Answers every request one cycle after it is seen, then drops ack.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? readMux : 32'h0000_0000;
    end
  end

  // Holds the three configuration words; masks keep reserved bits at zero.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avgCtl <= RST_AVG_CTL;
      inSel <= RST_IN_SEL;
      stepCtl <= RST_STEP_CTL;
    end
    else if (ce && busWrite)
    begin
      if (hitAvg)
        avgCtl <= mergeWrite(avgCtl, wb_dat_i, wb_sel_i, MASK_AVG_CTL);
      if (hitSel)
        inSel <= mergeWrite(inSel, wb_dat_i, wb_sel_i, MASK_IN_SEL);
      if (hitCtl)
        stepCtl <= mergeWrite(stepCtl, wb_dat_i, wb_sel_i, MASK_STEP_CTL);
    end
  end

  // ----------------------------------------
  // Step selection
  // ----------------------------------------
  state_type state;
  logic [2:0] stepIdx;
  logic [2:0] avgExp;
  logic [7:0] sampleCount;
  logic [ACC_W-1:0] acc;

  // Exponent seven is left to software to avoid; it simply averages 128.
  wire [7:0] sampleLimit = 8'h01 << avgExp;
  wire lastSample = sampleCount == sampleLimit - 8'h01;
  wire [3:0] curCtl = stepNibble(stepCtl, stepIdx);
  wire stepEnds = curCtl[CTL_END] || stepIdx == LAST_STEP;
  wire takeDone = state == ST_WAIT && convDone;
  wire stepFinish = takeDone && lastSample;
  wire seqFinish = stepFinish && stepEnds;
  wire startNow = state == ST_IDLE && seqStart;
  wire issueReq = startNow || (takeDone && !seqFinish);

  // The step that the next request belongs to.
  wire [2:0] reqStep = startNow ? 3'h0 : stepFinish ? stepIdx + 3'h1 : stepIdx;
  wire [3:0] reqSel = stepNibble(inSel, reqStep);
  wire [3:0] reqCtl = stepNibble(stepCtl, reqStep);

  // A differential pair i starts at input 2i; otherwise the field is the pin.
  wire [2:0] reqChannel = reqCtl[CTL_DIFF] ? {reqSel[1:0], 1'b0} : {1'b0, reqSel[1:0]};

  // ----------------------------------------
  // Averaging arithmetic
  // ----------------------------------------
  wire [ACC_W-1:0] sum = acc + {{EXP_MAX_BITS{1'b0}}, convData};
  wire [ACC_W-1:0] shifted = sum >> avgExp;
  wire [DATA_W-1:0] average = shifted[DATA_W-1:0];

  // Sequencer: issue, wait for each conversion, accumulate and advance.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      stepIdx <= 3'h0;
      avgExp <= 3'h0;
      sampleCount <= 8'h00;
      acc <= '0;
    end
    else if (ce)
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (seqStart)
          begin
            state <= ST_WAIT;
            stepIdx <= 3'h0;
            avgExp <= avgCtl[2:0];
            sampleCount <= 8'h00;
            acc <= '0;
          end
        end
        ST_WAIT:
        begin
          if (convDone)
          begin
            if (lastSample)
            begin
              sampleCount <= 8'h00;
              acc <= '0;
              stepIdx <= reqStep;
              if (stepEnds)
                state <= ST_IDLE;
            end
            else
            begin
              sampleCount <= sampleCount + 8'h01;
              acc <= sum;
            end
          end
        end
      endcase
    end
  end

  // Registers the request and its selection toward the converter core.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convReq <= 1'b0;
      convChannel <= 3'h0;
      convTempSel <= 1'b0;
      convDiff <= 1'b0;
    end
    else if (ce)
    begin
      convReq <= issueReq;
      if (issueReq)
      begin
        convChannel <= reqChannel;
        convTempSel <= reqCtl[CTL_TEMP];
        convDiff <= reqCtl[CTL_DIFF] & ~reqCtl[CTL_TEMP];
      end
    end
  end

  // Writes one averaged word per completed step and shows the busy state.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifoWrite <= 1'b0;
      fifoData <= '0;
      seqBusy <= 1'b0;
    end
    else if (ce)
    begin
      fifoWrite <= stepFinish;
      if (stepFinish)
        fifoData <= average;
      seqBusy <= startNow || (seqBusy && !seqFinish);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [7:0] doneSince;

  // Counts conversions taken since the last FIFO word.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      doneSince <= 8'h00;
    else if (ce)
      doneSince <= fifoWrite ? {7'h00, takeDone} : doneSince + {7'h00, takeDone};
  end

  a_avg_sample_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fifoWrite |-> doneSince == (8'h01 << avgExp))
    else $error("FIFO word not built from two-to-the-exponent conversions.");

  a_pass_through: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && takeDone && avgExp == 3'h0) |=> fifoWrite && fifoData == $past(convData))
    else $error("Single conversion was not forwarded unchanged.");

  a_shift_truncate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && stepFinish) |=> fifoData == $past(average) && fifoWrite)
    else $error("Averaged word differs from shifted sum.");

  a_input_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (convReq && !convDiff && !convTempSel) |->
      convChannel == {1'b0, inSel[{stepIdx, 2'b00} +: 2]})
    else $error("Requested input does not match the step field.");

  a_diff_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (convReq && convDiff) |-> convChannel == {inSel[{stepIdx, 2'b00} +: 2], 1'b0})
    else $error("Differential request not aligned to pair start.");

  a_temp_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    convReq |-> convTempSel == stepCtl[{stepIdx, 2'b00} + 5'(CTL_TEMP)])
    else $error("Temperature select does not follow the step flag.");

  a_end_stops: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && seqFinish) |=> state == ST_IDLE && !convReq ##1 !seqBusy)
    else $error("Sequence continued past its last step.");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (inSel & ~MASK_IN_SEL) == 32'h0000_0000 && avgCtl[31:3] == 29'h0000_0000)
    else $error("Reserved register bits are not zero.");

  a_ack_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && wb_ack_o) |=> !wb_ack_o)
    else $error("Bus ack lasted more than one cycle.");

  // ----------------------------------------
  // Sequence and handshake checks
  // ----------------------------------------
  a_ack_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && busReq) |=> wb_ack_o)
    else $error("Bus request was not acknowledged in the next cycle.");

  a_start_step0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && startNow) |=> convReq && seqBusy && stepIdx == 3'h0)
    else $error("Sequence did not begin with the first step.");

  a_step_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && stepFinish && !seqFinish) |=> convReq && stepIdx == $past(stepIdx) + 3'h1)
    else $error("Sequence did not move on to the next step.");

  a_req_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && convReq) |=> !convReq)
    else $error("Conversion request lasted more than one cycle.");

  a_temp_no_diff: assert property (@(posedge ref_clk) disable iff (!rst_n)
    convTempSel |-> !convDiff)
    else $error("Temperature sample was marked differential.");

  a_word_in_seq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fifoWrite |-> $past(seqBusy))
    else $error("FIFO word written outside a running sequence.");

  a_exp_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && state == ST_WAIT) |=> avgExp == $past(avgExp))
    else $error("Exponent changed in the middle of a sequence.");

  logic [3:0] wordsInSeq;

  // Counts the FIFO words of the running sequence; eight steps is the most.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wordsInSeq <= 4'h0;
    else if (ce)
      wordsInSeq <= startNow ? 4'h0 : wordsInSeq + {3'h0, fifoWrite};
  end

  a_words_bounded: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wordsInSeq <= 4'h8)
    else $error("Sequence wrote more than eight FIFO words.");

endmodule

// file: adc_avg_pkg.sv
// Constants, types and helpers for the averaging and input-select block.
package adc_avg_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_AVG_CTL = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_IN_SEL = 12'h040;
  localparam logic [ADDR_W-1:0] OFF_STEP_CTL = 12'h044;
  localparam logic [31:0] MASK_AVG_CTL = 32'h0000_0007;
  localparam logic [31:0] MASK_IN_SEL = 32'h3333_3333;
  localparam logic [31:0] MASK_STEP_CTL = 32'hffff_ffff;
  localparam logic [31:0] RST_AVG_CTL = 32'h0000_0000;
  localparam logic [31:0] RST_IN_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_STEP_CTL = 32'h0000_0000;

  // ----------------------------------------
  // Field positions inside one step nibble
  // ----------------------------------------
  localparam int CTL_DIFF = 0;
  localparam int CTL_END = 1;
  localparam int CTL_IRQ_EN = 2;
  localparam int CTL_TEMP = 3;
  localparam logic [2:0] LAST_STEP = 3'h7;
  localparam int EXP_MAX_BITS = 7;

  // Sequencer states.
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} state_type;

  // Picks the nibble that belongs to one step.
  function automatic logic [3:0] stepNibble(input logic [31:0] w, input logic [2:0] i);
    stepNibble = w[{i, 2'b00} +: 4];
  endfunction

  // Merges a write under byte selects and clears reserved bits.
  function automatic logic [31:0] mergeWrite(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] s,
                                             input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
        r[8*b +: 8] = d[8*b +: 8];
    end
    mergeWrite = r & m;
  endfunction

endpackage

// file: adc_core_model.sv
// Behavioural converter core that answers each conversion request once.
`timescale 1ns/100ps
module adc_core_model
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic convReq,
  input wire logic slow,
  output logic convDone,
  output logic [9:0] convData
);
  int seed = 99;
  int left = 0;

  // Waits a short or long time after a request, then pulses one result.
  // Between results the data churns so that stale values never look valid.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convDone <= 1'h0;
      convData <= 10'h155;
      left <= 0;
    end
    else
    begin
      convDone <= (left == 1);
      convData <= (left == 1) ? 10'($random(seed)) : ~convData;
      left <= convReq ? (slow ? 6 : 2) : (left > 0 ? left - 1 : 0);
    end
  end
endmodule

// file: adc_avg_mux_tb_top.sv
// Self-checking bench for the averaging and input-select block.
`timescale 1ns/100ps
module adc_avg_mux_tb_top;
  import adc_avg_pkg::*;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic wbCyc = 1'h0;
  logic wbStb = 1'h0;
  logic wbWe = 1'h0;
  logic [ADDR_W-1:0] wbAdr = 12'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDat = 32'h0;
  logic [31:0] wbDatO, rd;
  logic wbAck, seqBusy, convReq, convTempSel, convDiff, convDone, fifoWrite;
  logic seqStart = 1'h0;
  logic slow = 1'h0;
  logic [2:0] convChannel;
  logic [9:0] convData, fifoData;
  logic [31:0] inSel = 32'h0;
  logic [31:0] ctl = 32'h0;
  int badCount = 0;
  int nTests = 0;
  int seed = 99;
  int cycles = 0;
  int sum = 0;
  int cnt = 0;
  int k = 0;
  int nFifo = 0;
  int expW = 0;

  adc_avg_mux #(.DATA_W(10)) i_dut (.ref_clk, .rst_n, .ce(1'h1), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .seqStart, .seqBusy, .convReq, .convChannel,
    .convTempSel, .convDiff, .convDone, .convData, .fifoWrite, .fifoData);
  adc_core_model i_core (.ref_clk, .rst_n, .convReq, .slow, .convDone, .convData);

  // Clock generation and a ceiling on the run length.
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      badCount++;
      reportAndStop();
    end
  end

  // Counts one comparison and prints a line for a mismatch.
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  // Register read-back results.
  task automatic checkReg(input string what, input logic [31:0] e, input logic [31:0] g);
    chk(what, e, g);
  endtask

  // Averaged FIFO words and their sample counts.
  task automatic checkFifo(input string what, input logic [31:0] e, input logic [31:0] g);
    chk(what, e, g);
  endtask

  // Selection that goes out with each conversion request.
  task automatic checkReq(input string what, input logic [31:0] e, input logic [31:0] g);
    chk(what, e, g);
  endtask

  // Sequence status and the number of words per sequence.
  task automatic checkSeq(input string what, input logic [31:0] e, input logic [31:0] g);
    chk(what, e, g);
  endtask

  task automatic reportAndStop;
    if (badCount == 0 && nTests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One classic bus cycle; the request holds until ack is sampled high.
  task automatic wb_cycle(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] q);
    @(posedge ref_clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= s;
    do
    begin
      @(posedge ref_clk);
    end
    while (wbAck !== 1'h1);
    q = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  // Follows each request and sums results; every FIFO word is checked.
  always @(posedge ref_clk)
  begin
    if (fifoWrite === 1'h1)
    begin
      checkFifo("fifo data", sum >> expW, fifoData);
      checkFifo("samples per word", 1 << expW, cnt);
      sum = 0;
      cnt = 0;
      k++;
      nFifo++;
    end
    if (convReq === 1'h1)
    begin
      checkReq("temp select", ctl[4*k+3], convTempSel);
      checkReq("diff", ctl[4*k] & ~ctl[4*k+3], convDiff);
      if (!ctl[4*k+3])
        checkReq("channel", ctl[4*k] ? 2 * inSel[4*k +: 2] : inSel[4*k +: 2], convChannel);
    end
    if (convDone === 1'h1)
    begin
      sum += convData;
      cnt++;
    end
  end

  // Programs both tables, starts one sequence and waits for it to finish.
  task automatic run_seq(input int e, input int last);
    logic [31:0] raw;
    raw = $random(seed);
    inSel = raw & MASK_IN_SEL;
    ctl = ($random(seed) & 32'hdddd_dddd) | (last < 8 ? 32'h2 << (4 * last) : 32'h0);
    wb_cycle(OFF_AVG_CTL, 1'h1, 32'(e), 4'hf, rd);
    wb_cycle(OFF_IN_SEL, 1'h1, raw, 4'hf, rd);
    wb_cycle(OFF_STEP_CTL, 1'h1, ctl, 4'hf, rd);
    wb_cycle(OFF_IN_SEL, 1'h0, 32'h0, 4'hf, rd);
    checkReg("input select", inSel, rd);
    expW = e;
    k = 0;
    nFifo = 0;
    @(posedge ref_clk);
    seqStart <= 1'h1;
    // Start stays up one extra cycle, which a busy sequencer must ignore.
    repeat (2) @(posedge ref_clk);
    seqStart <= 1'h0;
    checkSeq("busy", 32'h1, seqBusy);
    while (seqBusy !== 1'h0)
    begin
      @(posedge ref_clk);
    end
    // One more edge lets the monitor count the final word first.
    @(posedge ref_clk);
    checkSeq("result count", last < 8 ? last + 1 : 8, nFifo);
    checkSeq("busy end", 32'h0, seqBusy);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    wb_cycle(OFF_AVG_CTL, 1'h0, 32'h0, 4'hf, rd);
    checkReg("avg reset", RST_AVG_CTL, rd);
    wb_cycle(OFF_IN_SEL, 1'h0, 32'h0, 4'hf, rd);
    checkReg("sel reset", RST_IN_SEL, rd);
    wb_cycle(OFF_AVG_CTL, 1'h1, 32'hffff_fffe, 4'hf, rd);
    wb_cycle(OFF_AVG_CTL, 1'h0, 32'h0, 4'hf, rd);
    checkReg("avg mask", 32'h6, rd);
    wb_cycle(OFF_IN_SEL, 1'h1, 32'hffff_ffff, 4'hf, rd);
    wb_cycle(OFF_IN_SEL, 1'h1, 32'h0, 4'h2, rd);
    wb_cycle(OFF_IN_SEL, 1'h0, 32'h0, 4'hf, rd);
    checkReg("sel lanes", 32'h3333_0033, rd);
    wb_cycle(12'h050, 1'h1, 32'hffff_ffff, 4'hf, rd);
    wb_cycle(12'h050, 1'h0, 32'h0, 4'hf, rd);
    checkReg("unmapped", 32'h0, rd);
    for (int e = 0; e <= 6; e++)
    begin
      slow <= e[0];
      run_seq(e, e);
    end
    run_seq(2, 8);
    reportAndStop();
  end
endmodule
